/* File: logic/pssp_dev.sv */
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - answers only after reset sequence completes
// - mode inputs may change at any time
// - host should fix mode in boot config
// - chip-select and serial-in pins form address bits
// - SPI: no two-wire drive, serial-in gated
// - 16-bit space, user registers upper half only
// - own page register, paged or full addressing
// - base address register, default 1011000b
// - pin levels set address bits 0 and 1
// - optional gpio strap sets address bit 2
// - answer only the composed base address
// - one or two offset bytes, all used
// - one-byte mode: page supplies high byte
// - page register at 0xFC, four-byte burst
// - two-byte mode: full address, page 0xFFFC
// - host keeps multi-byte registers in one burst
// - host bursts stay within 0xFF page
// - pointer advances after every data byte
// - works at 100k, 400k and 1M
// - host reads via offset write, repeated start
module pssp_dev import pssp_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  pssp_if.dev              link,
  input  wire logic        seq_done,
  input  wire logic        spi_mode,
  input  wire logic        three_wire,
  input  wire logic        two_byte_mode,
  input  wire logic        cfg_base_load,
  input  wire logic [6:0]  cfg_base_addr,
  input  wire logic        strap_bit2_en,
  input  wire logic        gpio_strap,
  output logic      [15:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_we,
  output logic             reg_re,
  input  wire logic [7:0]  reg_rdata,
  output logic      [31:0] page_select,
  output logic             spi_serial_in
);
  typedef enum {DS_IDLE, DS_DEV, DS_OFH, DS_OFL, DS_WR, DS_RD} pssp_dst_t;

  pssp_dst_t   st;
  logic [1:0]  scl_sync, sda_sync, bit0_sync, bit1_sync, gpio_sync;
  logic        scl_prev, sda_prev;
  logic        scl_s, sda_s, scl_rise, scl_fall, start_seen, stop_seen;
  logic        active, addr_strap_bit_two, strap_taken;
  logic [1:0]  strap_cnt;
  logic [6:0]  base_reg, my_addr;
  logic [3:0]  bitcnt;
  logic        ack_slot, rd_pend, fetch_now;
  logic [7:0]  sh, rd_sh, rd_byte;
  logic [15:0] ptr, ptr_inc, eff_addr, fetch_ptr, fetch_addr;
  logic [31:0] pg_shadow;
  logic [3:0]  pg_seen;

  // ----------------------------------------------------------------
  // address decoding helpers
  // ----------------------------------------------------------------
  function automatic logic page_hit(input logic [15:0] p, input logic tb);
    if (tb) page_hit = (p[15:2] == PSSP_PAGE_OFS_2B[15:2]);
    else    page_hit = (p[7:2] == PSSP_PAGE_OFS_1B[7:2]);
  endfunction

  function automatic logic [15:0] full_addr(input logic [15:0] p, input logic tb,
                                            input logic [7:0] hi);
    full_addr = tb ? p : {hi, p[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // all pins cross into mclk through two flops; edges use stage [1] only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      bit0_sync <= 2'h0;
      bit1_sync <= 2'h0;
      gpio_sync <= 2'h0;
      scl_prev  <= 1'h1;
      sda_prev  <= 1'h1;
    end else begin
      scl_sync  <= {scl_sync[0], link.bus_clk};
      sda_sync  <= {sda_sync[0], link.bus_data};
      bit0_sync <= {bit0_sync[0], link.addr_strap_bit_zero};
      bit1_sync <= {bit1_sync[0], link.serial_in_pin};
      gpio_sync <= {gpio_sync[0], gpio_strap};
      scl_prev  <= scl_sync[1];
      sda_prev  <= sda_sync[1];
    end
  end

  assign scl_s      = scl_sync[1];
  assign sda_s      = sda_sync[1];
  assign scl_rise   = scl_s & ~scl_prev;
  assign scl_fall   = ~scl_s & scl_prev;
  assign start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_seen  = scl_s & scl_prev & ~sda_prev & sda_s;

  // silent before boot completes or while in SPI mode
  assign active = seq_done & ~spi_mode;

  // serial input only reaches SPI framing in four-wire mode
  always_ff @(posedge mclk) begin
    if (!rst_n) spi_serial_in <= 1'h0;
    else        spi_serial_in <= spi_mode & ~three_wire & bit1_sync[1];
  end

  // ----------------------------------------------------------------
  // slave base address
  // ----------------------------------------------------------------
  // stored base, default value
  always_ff @(posedge mclk) begin
    if (!rst_n)             base_reg <= PSSP_BASE_DEFAULT;
    else if (cfg_base_load) base_reg <= cfg_base_addr;
  end

  // strap caught once the synchroniser has filled after release
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_cnt          <= 2'h0;
      strap_taken        <= 1'h0;
      addr_strap_bit_two <= 1'h0;
    end else if (!strap_taken) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h2) begin
        strap_taken        <= 1'h1;
        addr_strap_bit_two <= gpio_sync[1];
      end
    end
  end

  // pins supply the two lowest address bits
  assign my_addr = {base_reg[6:3], strap_bit2_en ? addr_strap_bit_two : base_reg[2],
                    bit1_sync[1], bit0_sync[1]};

  // ----------------------------------------------------------------
  // pointer arithmetic
  // ----------------------------------------------------------------
  // one-byte mode wraps inside the page; staying inside is the host's job
  assign ptr_inc    = two_byte_mode ? ptr + 16'h0001 : {ptr[15:8], ptr[7:0] + 8'h01};
  assign eff_addr   = full_addr(ptr, two_byte_mode, page_select[15:8]);
  assign fetch_ptr  = (st == DS_RD) ? ptr_inc : ptr;
  assign fetch_addr = full_addr(fetch_ptr, two_byte_mode, page_select[15:8]);
  assign fetch_now  = active && scl_fall && !ack_slot && (bitcnt == 4'h8) &&
                      ((st == DS_DEV && sh[7:1] == my_addr && sh[0]) || st == DS_RD);

  // register read answers one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) rd_pend <= 1'h0;
    else        rd_pend <= reg_re;
  end

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  // all decisions ride on sampled edges, so 1 MHz leaves 20 cycles a bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st              <= DS_IDLE;
      bitcnt          <= 4'h0;
      ack_slot        <= 1'h0;
      sh              <= 8'h00;
      rd_sh           <= 8'h00;
      rd_byte         <= 8'h00;
      ptr             <= 16'h0000;
      pg_shadow       <= PSSP_PAGE_RESET;
      pg_seen         <= 4'h0;
      page_select     <= PSSP_PAGE_RESET;
      reg_addr        <= 16'h0000;
      reg_wdata       <= 8'h00;
      reg_we          <= 1'h0;
      reg_re          <= 1'h0;
      link.dev_sda_oe <= 1'h0;
      link.dev_sda_o  <= 1'h0;
    end else begin
      reg_we <= 1'h0;
      reg_re <= 1'h0;
      // a mode change takes effect on the next decision
      if (!active || stop_seen) begin
        st              <= DS_IDLE;
        ack_slot        <= 1'h0;
        link.dev_sda_oe <= 1'h0;
      end else if (start_seen) begin
        st              <= DS_DEV;
        bitcnt          <= 4'h0;
        ack_slot        <= 1'h0;
        pg_seen         <= 4'h0;
        link.dev_sda_oe <= 1'h0;
      end else if (st != DS_IDLE && scl_rise) begin
        if (ack_slot) begin
          // master nack closes the read
          if (st == DS_RD && sda_s) st <= DS_IDLE;
        end else begin
          sh     <= {sh[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
      end else if (st != DS_IDLE && scl_fall) begin
        if (ack_slot) begin
          ack_slot        <= 1'h0;
          bitcnt          <= 4'h0;
          link.dev_sda_oe <= (st == DS_RD) & ~rd_byte[7];
          rd_sh           <= {rd_byte[6:0], 1'h0};
        end else if (bitcnt == 4'h8) begin
          ack_slot        <= 1'h1;
          link.dev_sda_oe <= 1'h1;
          unique case (st)
            DS_DEV: begin
              // only the composed address is answered
              if (sh[7:1] != my_addr) begin
                st              <= DS_IDLE;
                ack_slot        <= 1'h0;
                link.dev_sda_oe <= 1'h0;
              end else if (sh[0]) begin
                st <= DS_RD;
              end else begin
                // offset width picks one or two bytes
                st <= two_byte_mode ? DS_OFH : DS_OFL;
              end
            end
            DS_OFH: begin
              ptr[15:8] <= sh;
              st        <= DS_OFL;
            end
            DS_OFL: begin
              ptr[7:0] <= sh;
              st       <= DS_WR;
            end
            DS_WR: begin
              ptr <= ptr_inc;
              if (page_hit(ptr, two_byte_mode)) begin
                pg_shadow[{ptr[1:0], 3'h0} +: 8] <= sh;
                pg_seen[ptr[1:0]]                <= 1'h1;
                if (ptr[1:0] == 2'h3 && &pg_seen[2:0]) page_select <= {sh, pg_shadow[23:0]};
              end else if (eff_addr[PSSP_USER_BIT]) begin
                reg_we    <= 1'h1;
                reg_addr  <= eff_addr;
                reg_wdata <= sh;
              end
            end
            DS_RD: begin
              link.dev_sda_oe <= 1'h0;
              ptr             <= ptr_inc;
            end
            DS_IDLE: ;
          endcase
        end else if (st == DS_RD) begin
          link.dev_sda_oe <= ~rd_sh[7];
          rd_sh           <= {rd_sh[6:0], 1'h0};
        end
      end
      // next read byte fetched during the ack slot
      if (fetch_now) begin
        if (page_hit(fetch_ptr, two_byte_mode)) begin
          rd_byte <= page_select[{fetch_ptr[1:0], 3'h0} +: 8];
        end else if (!fetch_addr[PSSP_USER_BIT]) begin
          rd_byte <= 8'h00;
        end else begin
          reg_re   <= 1'h1;
          reg_addr <= fetch_addr;
        end
      end else if (rd_pend) begin
        rd_byte <= reg_rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/pssp_pkg.sv */
package pssp_pkg;
  // ----------------------------------------------------------------
  // clocking and link rates
  // ----------------------------------------------------------------
  localparam int PSSP_MCLK_HZ        = 20_000_000;
  localparam int PSSP_SCL_STD_HZ     = 100_000;
  localparam int PSSP_SCL_FAST_HZ    = 400_000;
  localparam int PSSP_SCL_FASTP_HZ   = 1_000_000;
  localparam int PSSP_SCL_DEFAULT_HZ = PSSP_SCL_FAST_HZ;
  // quarter bit-time at the default 400k rate in mclk cycles, rounded up
  localparam int PSSP_QUARTER_CYC    =
    (PSSP_MCLK_HZ + 4 * PSSP_SCL_DEFAULT_HZ - 1) / (4 * PSSP_SCL_DEFAULT_HZ);
  localparam int PSSP_QUARTER_MIN    = 4;

  // ----------------------------------------------------------------
  // device side: base address and page register
  // ----------------------------------------------------------------
  localparam logic [6:0]  PSSP_BASE_DEFAULT = 7'h58;
  localparam logic [7:0]  PSSP_PAGE_OFS_1B  = 8'hFC;
  localparam logic [15:0] PSSP_PAGE_OFS_2B  = 16'hFFFC;
  localparam logic [31:0] PSSP_PAGE_RESET   = 32'h0000_0000;
  localparam int          PSSP_USER_BIT     = 15;

  // ----------------------------------------------------------------
  // host command port map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] PSSP_H_CTRL   = 5'h00;
  localparam logic [4:0] PSSP_H_DEV    = 5'h04;
  localparam logic [4:0] PSSP_H_OFS    = 5'h08;
  localparam logic [4:0] PSSP_H_DATA   = 5'h0C;
  localparam logic [4:0] PSSP_H_STAT   = 5'h10;
  localparam int PSSP_CTRL_GO    = 0;
  localparam int PSSP_CTRL_RD    = 1;
  localparam int PSSP_CTRL_2B    = 2;
  localparam int PSSP_CTRL_LEN   = 4;
  localparam int PSSP_DEV_STRAP  = 8;
  localparam int PSSP_STAT_BUSY  = 0;
  localparam int PSSP_STAT_NACK  = 1;
endpackage

/* File: logic/pssp_if.sv */
`timescale 1ns/1ns
`default_nettype none
// two-wire link between host end and device end
interface pssp_if;
  logic bus_clk;             // bus clock, made by the host
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic bus_data;            // resolved open-drain data level
  logic addr_strap_bit_zero; // chip-select pin, address bit 0 in two-wire mode
  logic serial_in_pin;       // serial input pin, address bit 1 in two-wire mode

  // pull-up: low whenever any enabled driver pulls low
  assign bus_data = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (
    input  bus_clk,
    input  bus_data,
    input  addr_strap_bit_zero,
    input  serial_in_pin,
    output dev_sda_o,
    output dev_sda_oe
  );
  modport host (
    output bus_clk,
    output host_sda_o,
    output host_sda_oe,
    output addr_strap_bit_zero,
    output serial_in_pin,
    input  bus_data
  );
endinterface
`default_nettype wire

/* File: logic/pssp_host.sv */
`timescale 1ns/1ns
`default_nettype none
// two-wire master: offset write plus burst write, or offset write plus repeated-start read
module pssp_host import pssp_pkg::*; #(
  parameter int SCL_HZ = PSSP_SCL_DEFAULT_HZ
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  pssp_if.host             link,
  input  wire logic [4:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic      [31:0] cmd_rdata
);
  localparam int QUARTER = (PSSP_MCLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

  generate
    if (QUARTER < PSSP_QUARTER_MIN) begin : g_rate_check
      $error("bus clock too fast for the device sampler");
    end
  endgenerate

  typedef enum {HS_IDLE, HS_START, HS_BIT, HS_STOP} pssp_hst_t;
  typedef enum {PH_DEV, PH_OFH, PH_OFL, PH_WD, PH_RDEV, PH_RD} pssp_phase_t;

  pssp_hst_t   st;
  pssp_phase_t ph;
  logic        rd_mode, two_byte, busy, nack, ackbit;
  logic [1:0]  len, cnt, q;
  logic [6:0]  dev_addr;
  logic [1:0]  straps;
  logic [15:0] offset;
  logic [31:0] wdata, rdata;
  logic [7:0]  sh;
  logic [3:0]  bitn;
  logic [15:0] qcnt;
  logic [1:0]  sda_sync;
  logic        tick, tx, last, go;

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k);
    byte_of = w[{k, 3'h0} +: 8];
  endfunction

  assign tick = (st != HS_IDLE) && (qcnt == 16'(QUARTER - 1));
  assign tx   = (ph != PH_RD);
  assign last = (cnt == len);
  assign go   = cmd_wr && (cmd_addr == PSSP_H_CTRL) && cmd_wdata[PSSP_CTRL_GO] && !busy;

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  // writes while busy are refused so the frame sees stable settings
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_mode  <= 1'h0;
      two_byte <= 1'h0;
      len      <= 2'h0;
      dev_addr <= PSSP_BASE_DEFAULT;
      straps   <= 2'h0;
      offset   <= 16'h0000;
      wdata    <= 32'h0000_0000;
    end else if (cmd_wr && !busy) begin
      unique case (cmd_addr)
        PSSP_H_CTRL: begin
          rd_mode  <= cmd_wdata[PSSP_CTRL_RD];
          two_byte <= cmd_wdata[PSSP_CTRL_2B];
          len      <= cmd_wdata[PSSP_CTRL_LEN +: 2];
        end
        PSSP_H_DEV: begin
          dev_addr <= cmd_wdata[6:0];
          straps   <= cmd_wdata[PSSP_DEV_STRAP +: 2];
        end
        PSSP_H_OFS:  offset <= cmd_wdata[15:0];
        PSSP_H_DATA: wdata  <= cmd_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_rdata <= 32'h0000_0000;
    end else if (cmd_rd) begin
      unique case (cmd_addr)
        PSSP_H_CTRL: cmd_rdata <= {26'h0, len, 1'h0, two_byte, rd_mode, 1'h0};
        PSSP_H_DEV:  cmd_rdata <= {22'h0, straps, 1'h0, dev_addr};
        PSSP_H_OFS:  cmd_rdata <= {16'h0, offset};
        PSSP_H_DATA: cmd_rdata <= rdata;
        PSSP_H_STAT: cmd_rdata <= {30'h0, nack, busy};
        default:     cmd_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // strap pins are held static while the two-wire bus runs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.addr_strap_bit_zero <= 1'h0;
      link.serial_in_pin       <= 1'h0;
      sda_sync                 <= 2'h3;
    end else begin
      link.addr_strap_bit_zero <= straps[0];
      link.serial_in_pin       <= straps[1];
      sda_sync                 <= {sda_sync[0], link.bus_data};
    end
  end

  // ----------------------------------------------------------------
  // bit engine: four quarters per bit, clock made by divider
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st               <= HS_IDLE;
      ph               <= PH_DEV;
      busy             <= 1'h0;
      nack             <= 1'h0;
      ackbit           <= 1'h0;
      cnt              <= 2'h0;
      q                <= 2'h0;
      qcnt             <= 16'h0000;
      sh               <= 8'h00;
      bitn             <= 4'h0;
      rdata            <= 32'h0000_0000;
      link.bus_clk     <= 1'h1;
      link.host_sda_oe <= 1'h0;
      link.host_sda_o  <= 1'h0;
    end else if (go) begin
      st   <= HS_START;
      ph   <= PH_DEV;
      busy <= 1'h1;
      nack <= 1'h0;
      q    <= 2'h0;
      qcnt <= 16'h0000;
      sh   <= {dev_addr, 1'h0};
    end else if (st != HS_IDLE) begin
      qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
      if (tick) begin
        q <= q + 2'h1;
        unique case (st)
          HS_START: begin
            unique case (q)
              2'h0: link.host_sda_oe <= 1'h0;
              2'h1: link.bus_clk     <= 1'h1;
              2'h2: link.host_sda_oe <= 1'h1;
              2'h3: begin
                link.bus_clk <= 1'h0;
                st           <= HS_BIT;
                bitn         <= 4'h0;
              end
            endcase
          end
          HS_BIT: begin
            unique case (q)
              2'h0: begin
                if (bitn != 4'h8) link.host_sda_oe <= tx & ~sh[7];
                else              link.host_sda_oe <= ~tx & ~last;
              end
              2'h1: link.bus_clk <= 1'h1;
              2'h2: begin
                if (bitn != 4'h8) sh <= {sh[6:0], sda_sync[1]};
                else              ackbit <= sda_sync[1];
              end
              2'h3: begin
                link.bus_clk <= 1'h0;
                bitn         <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
                if (bitn == 4'h8) begin
                  if (tx && ackbit) begin
                    nack <= 1'h1;
                    st   <= HS_STOP;
                  end else begin
                    unique case (ph)
                      PH_DEV: begin
                        ph <= two_byte ? PH_OFH : PH_OFL;
                        sh <= two_byte ? offset[15:8] : offset[7:0];
                      end
                      PH_OFH: begin
                        ph <= PH_OFL;
                        sh <= offset[7:0];
                      end
                      PH_OFL: begin
                        cnt <= 2'h0;
                        ph  <= rd_mode ? PH_RDEV : PH_WD;
                        st  <= rd_mode ? HS_START : HS_BIT;
                        sh  <= rd_mode ? {dev_addr, 1'h1} : byte_of(wdata, 2'h0);
                      end
                      PH_WD: begin
                        if (last) st <= HS_STOP;
                        cnt <= cnt + 2'h1;
                        sh  <= byte_of(wdata, cnt + 2'h1);
                      end
                      PH_RDEV: ph <= PH_RD;
                      PH_RD: begin
                        rdata[{cnt, 3'h0} +: 8] <= sh;
                        if (last) st <= HS_STOP;
                        cnt <= cnt + 2'h1;
                      end
                    endcase
                  end
                end
              end
            endcase
          end
          HS_STOP: begin
            unique case (q)
              2'h0: link.host_sda_oe <= 1'h1;
              2'h1: link.bus_clk     <= 1'h1;
              2'h2: link.host_sda_oe <= 1'h0;
              2'h3: begin
                st   <= HS_IDLE;
                busy <= 1'h0;
              end
            endcase
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/pssp_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module pssp_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic bus_clk,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic bus_data,
  input wire logic addr_strap_bit_zero,
  input wire logic serial_in_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // open-drain: a driver may only pull low
  AST_DEV_LOW: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives high");
  AST_HOST_LOW: assert property (host_sda_oe |-> !host_sda_o)
    else $error("host drives high");
  // device data moves only once the clock fall has settled
  AST_DEV_EDGE: assert property ($changed(dev_sda_oe) |-> !bus_clk && !$past(bus_clk, 2))
    else $error("device data moved early");
  AST_ACK_LAG: assert property ($rose(dev_sda_oe) |-> $past(bus_clk, 8))
    else $error("device drive late");
  AST_ACK_HOLD: assert property ($rose(dev_sda_oe) |=> dev_sda_oe [*8])
    else $error("device drive short");
  AST_CLK_HIGH: assert property ($rose(bus_clk) |=> bus_clk [*8])
    else $error("clock high short");
  AST_CLK_LOW: assert property ($fell(bus_clk) |=> !bus_clk [*8])
    else $error("clock low short");
  // straps may only move while the bus idles
  AST_STRAP_STATIC: assert property (
    $changed({addr_strap_bit_zero, serial_in_pin}) |-> bus_clk && bus_data)
    else $error("straps moved in transfer");
  cover property (bus_clk && $fell(bus_data));
  cover property (bus_clk && $rose(bus_data));
  cover property ($rose(dev_sda_oe));
endmodule
`default_nettype wire

/* File: tb/paged_serial_slave_port_test.sv */
`timescale 1ns/1ns
`default_nettype none
module paged_serial_slave_port_test import pssp_pkg::*;;
  logic mclk = 1'b0, rst_n = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0;
  logic seq_done = 1'b0, spi_mode = 1'b0, three_wire = 1'b0, two_byte_mode = 1'b0;
  logic cfg_base_load = 1'b0, strap_bit2_en = 1'b1, gpio_strap = 1'b1;
  logic [6:0] cfg_base_addr = 7'h00;
  logic [4:0] cmd_addr = 5'h00;
  logic [7:0] reg_rdata = 8'h00, reg_wdata, o;
  logic [15:0] reg_addr, a16, wq_a[$];
  logic [31:0] cmd_wdata = 32'h0, cmd_rdata, page_select, pg, d, v, ex;
  logic [7:0] wq_d[$];
  logic reg_we, reg_re, spi_serial_in;
  int err_count = 0, total_checks = 0, cyc = 0;
  always #25 mclk = ~mclk;
  pssp_if link ();
  pssp_host #(.SCL_HZ(PSSP_SCL_FASTP_HZ)) pssp_host_inst (.mclk(mclk), .rst_n(rst_n),
    .link(link), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
  pssp_dev pssp_dev_inst (.mclk(mclk), .rst_n(rst_n), .link(link), .seq_done(seq_done),
    .spi_mode(spi_mode), .three_wire(three_wire), .two_byte_mode(two_byte_mode),
    .cfg_base_load(cfg_base_load), .cfg_base_addr(cfg_base_addr),
    .strap_bit2_en(strap_bit2_en), .gpio_strap(gpio_strap), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .page_select(page_select), .spi_serial_in(spi_serial_in));
  pssp_monitor pssp_monitor_inst (.mclk(mclk), .rst_n(rst_n), .bus_clk(link.bus_clk),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .bus_data(link.bus_data),
    .addr_strap_bit_zero(link.addr_strap_bit_zero), .serial_in_pin(link.serial_in_pin));
  // register contents derived from the address, so reads need no memory
  function automatic logic [7:0] rval(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  // composed address: fixed top, gpio strap on bit 2, pins below
  function automatic logic [6:0] dv(input logic [1:0] s);
    return {4'hB, 1'b1, s};
  endfunction
  // register port stand-in and write log
  always @(posedge mclk) begin
    if (reg_re) reg_rdata <= rval(reg_addr);
    if (reg_we) begin
      wq_a.push_back(reg_addr);
      wq_d.push_back(reg_wdata);
    end
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] x);
    @(posedge mclk);
    cmd_addr <= a;
    cmd_wdata <= x;
    cmd_wr <= 1'b1;
    @(posedge mclk);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge mclk);
    cmd_rd <= 1'b0;
    @(posedge mclk);
    v = cmd_rdata;
  endtask
  // one bus transaction, polled to completion; status left in v
  task automatic run(input logic [6:0] a, input logic [1:0] s, input logic [15:0] f,
                     input logic [31:0] x, input logic [7:0] c);
    wq_a.delete();
    wq_d.delete();
    wr(PSSP_H_DEV, {22'h0, s, 1'b0, a});
    wr(PSSP_H_OFS, {16'h0, f});
    wr(PSSP_H_DATA, x);
    wr(PSSP_H_CTRL, {24'h0, c});
    for (int i = 0; i < 400; i++) begin
      rd(PSSP_H_STAT);
      if (v[PSSP_STAT_BUSY] === 1'b0) break;
      repeat (20) @(posedge mclk);
    end
    chk("done", v[PSSP_STAT_BUSY], 1'b0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    v = $urandom(32'hA4EC);
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    run(dv(2'h3), 2'h3, 16'h00FC, 32'h0, 8'h31);
    chk("early", v[PSSP_STAT_NACK], 1'b1);
    seq_done <= 1'b1;
    pg = $urandom | 32'h0000_8000;
    // three bytes only: page must stay put
    run(dv(2'h3), 2'h3, 16'h00FC, pg, 8'h21);
    chk("page3", page_select, 32'h0);
    run(dv(2'h3), 2'h3, 16'h00FC, pg, 8'h31);
    chk("page", page_select, pg);
    run(dv(2'h3), 2'h3, 16'h00FC, 32'h0, 8'h33);
    rd(PSSP_H_DATA);
    chk("pgrd", v, pg);
    repeat (3) begin
      o = 8'($urandom_range(0, 248));
      d = $urandom;
      run(dv(2'h3), 2'h3, {8'h00, o}, d, 8'h31);
      chk("wcnt", 32'(wq_a.size()), 32'd4);
      for (int k = 0; k < 4; k++) begin
        chk("waddr", {16'h0, wq_a[k]}, {16'h0, pg[15:8], 8'(o + k)});
        chk("wdata", {24'h0, wq_d[k]}, {24'h0, d[8*k +: 8]});
        ex[8*k +: 8] = rval({pg[15:8], 8'(o + k)});
      end
      run(dv(2'h3), 2'h3, {8'h00, o}, 32'h0, 8'h33);
      rd(PSSP_H_DATA);
      chk("rdata", v, ex);
    end
    for (int s = 0; s < 4; s++) begin
      run(dv(2'(s)), 2'(s), 16'h0010, 32'h0, 8'h01);
      chk("strap", v[PSSP_STAT_NACK], 1'b0);
      run(dv(2'(s)) ^ 7'h04, 2'(s), 16'h0010, 32'h0, 8'h01);
      chk("gpio", v[PSSP_STAT_NACK], 1'b1);
      chk("nowr", 32'(wq_a.size()), 32'd0);
    end
    two_byte_mode <= 1'b1;
    a16 = 16'h8000 | 16'($urandom_range(0, 16'h7000));
    run(dv(2'h3), 2'h3, a16, d, 8'h15);
    chk("a2b", {16'h0, wq_a[1]}, {16'h0, a16 + 16'h1});
    run(dv(2'h3), 2'h3, 16'h7FFE, d, 8'h15);
    chk("low", 32'(wq_a.size()), 32'd0);
    run(dv(2'h3), 2'h3, 16'hFFFC, ~pg, 8'h35);
    chk("page2b", page_select, ~pg);
    spi_mode <= 1'b1;
    run(dv(2'h3), 2'h3, 16'h8000, d, 8'h15);
    chk("spi", v[PSSP_STAT_NACK], 1'b1);
    chk("sdi", spi_serial_in, 1'b1);
    three_wire <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("sdi3", spi_serial_in, 1'b0);
    spi_mode <= 1'b0;
    strap_bit2_en <= 1'b0;
    cfg_base_addr <= 7'h20;
    cfg_base_load <= 1'b1;
    @(posedge mclk);
    cfg_base_load <= 1'b0;
    run(7'h23, 2'h3, 16'h8000, d, 8'h15);
    chk("base", v[PSSP_STAT_NACK], 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
